// ===== inc/bce_pkg.sv
// constants, register map and types shared by the block cipher engine
package bce_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned BLOCK_W = 128;
  localparam int unsigned BYTES   = 16;
  localparam int unsigned IDX_W   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;  // control, start field write only
  localparam logic [7:0] ADDR_STATUS = 8'h01;  // status, read clears event bit
  localparam logic [7:0] ADDR_MASK   = 8'h02;  // interrupt mask
  localparam logic [3:0] PAGE_STATE  = 4'h1;   // state bytes at 0x10..0x1f
  localparam logic [3:0] PAGE_KEY    = 4'h2;   // key bytes at 0x20..0x2f
  localparam logic [3:0] LAST_BYTE   = 4'hf;   // final state byte index

  // control fields
  localparam int unsigned CTRL_START   = 0;    // self clearing start
  localparam int unsigned CTRL_DECRYPT = 1;    // 1 = decrypt direction
  localparam int unsigned CTRL_AUTO    = 2;    // auto-start on last byte
  localparam int unsigned CTRL_XOR     = 3;    // xor load of state bytes

  // status fields
  localparam int unsigned ST_DONE_EV = 0;      // sticky completion event
  localparam int unsigned ST_DONE    = 1;      // completion flag
  localparam int unsigned ST_BUSY    = 2;      // operation running

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] ZERO_B   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned LATENCY = 375;          // cycles from start to result
  localparam int unsigned ROUNDS  = 16;           // transform rounds
  localparam int unsigned FIN_CNT = LATENCY - 2;  // run count of last busy cycle
  localparam int unsigned CNT_W   = 9;

  typedef enum logic {BCE_IDLE, BCE_RUN} bce_state_e;

endpackage : bce_pkg

// ===== logic/bce_mem.sv
// sixteen byte memory with byte writes, whole block load and register outputs
`timescale 1ns/1ps
module bce_mem #(
  parameter int unsigned NBYTES = 16  // bytes held
) (
  input  wire logic                  sys_clk_in,  // clock
  input  wire logic                  rst_b_in,    // async reset, active low
  input  wire logic                  wr_in,       // byte write strobe
  input  wire logic [3:0]            idx_in,      // byte index
  input  wire logic [7:0]            wdata_in,    // byte data
  input  wire logic                  load_in,     // whole block load
  input  wire logic [NBYTES*8-1:0]   block_in,    // block load data
  output logic      [NBYTES*8-1:0]   block_out    // stored contents
);

  initial begin
    if (NBYTES != 16) $error("bce_mem supports sixteen bytes only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage: a block load takes priority over a byte write
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      block_out <= '0;
    end else if (load_in) begin
      block_out <= block_in;
    end else if (wr_in) begin
      block_out[idx_in*8 +: 8] <= wdata_in;
    end
  end

endmodule : bce_mem

// ===== logic/bce_engine.sv
// block cipher engine: register port, key and state memories, round datapath
//
// Summary of operation
// - one 128-bit block per run, 128-bit key
// - result ready 375 cycles after start
// - completion interrupt only when software enabled it
// - completion pulses the transfer trigger output
// - auto-start on write of last state byte
// - xor mode combines written byte with stored
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module bce_engine (
  input  wire logic       sys_clk_in,     // 200 MHz clock
  input  wire logic       rst_b_in,       // async reset, active low
  input  wire logic [7:0] reg_addr_in,    // register address
  input  wire logic [7:0] reg_wdata_in,   // write data
  input  wire logic       reg_wr_in,      // write strobe
  input  wire logic       reg_rd_in,      // read strobe
  output logic      [7:0] reg_rdata_out,  // read data, cycle after strobe
  output logic            irq_out,        // level interrupt
  output logic            dma_trig_out,   // one cycle completion trigger
  output logic            busy_out        // operation running
);

  initial begin
    if (bce_pkg::FIN_CNT <= bce_pkg::ROUNDS) $error("latency too short for rounds");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  bce_pkg::bce_state_e         state_reg;
  logic [bce_pkg::CNT_W-1:0]   cnt_reg;
  logic [7:0]                  ctrl_reg;
  logic [7:0]                  mask_reg;
  logic                        done_ev_reg;
  logic                        done_reg;
  logic [127:0]                work_reg;
  logic [127:0]                work_next;
  logic [127:0]                state_flat;
  logic [127:0]                key_flat;
  logic [3:0]                  idx;
  logic                        is_state;
  logic                        is_key;
  logic                        busy;
  logic                        wr_state;
  logic                        wr_key;
  logic                        start_cmd;
  logic                        auto_go;
  logic                        go;
  logic                        finish;
  logic                        rd_status;
  logic [7:0]                  state_wbyte;
  logic [7:0]                  status_val;
  logic [7:0]                  rdata_next;
  logic [bce_pkg::CNT_W-1:0]   rnd;
  logic [63:0]                 rkey;

  ////////////////////////////////////////////////////////////////////////////
  // address decode and strobes
  assign idx       = reg_addr_in[3:0];
  assign is_state  = (reg_addr_in[7:4] == bce_pkg::PAGE_STATE);
  assign is_key    = (reg_addr_in[7:4] == bce_pkg::PAGE_KEY);
  assign busy      = (state_reg == bce_pkg::BCE_RUN);
  assign wr_state  = reg_wr_in && is_state && !busy;  // memories frozen while running
  assign wr_key    = reg_wr_in && is_key && !busy;
  assign start_cmd = reg_wr_in && (reg_addr_in == bce_pkg::ADDR_CTRL)
                     && reg_wdata_in[bce_pkg::CTRL_START] && !busy;
  assign auto_go   = wr_state && ctrl_reg[bce_pkg::CTRL_AUTO] && (idx == bce_pkg::LAST_BYTE);
  assign go        = start_cmd || auto_go;
  assign finish    = busy && (cnt_reg == bce_pkg::CNT_W'(bce_pkg::FIN_CNT));
  assign rd_status = reg_rd_in && (reg_addr_in == bce_pkg::ADDR_STATUS);
  assign busy_out  = busy;

  // xor load folds the incoming byte into the stored one
  assign state_wbyte = ctrl_reg[bce_pkg::CTRL_XOR]
                       ? (reg_wdata_in ^ state_flat[idx*8 +: 8]) : reg_wdata_in;

  ////////////////////////////////////////////////////////////////////////////
  // key and state memories
  bce_mem #(.NBYTES(bce_pkg::BYTES)) u_state_mem (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .wr_in      (wr_state),
    .idx_in     (idx),
    .wdata_in   (state_wbyte),
    .load_in    (finish),
    .block_in   (work_reg),
    .block_out  (state_flat)
  );

  bce_mem #(.NBYTES(bce_pkg::BYTES)) u_key_mem (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .wr_in      (wr_key),
    .idx_in     (idx),
    .wdata_in   (reg_wdata_in),
    .load_in    (1'b0),
    .block_in   ('0),
    .block_out  (key_flat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control and mask registers; start bit is not stored
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= bce_pkg::CTRL_RST;
      mask_reg <= bce_pkg::MASK_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == bce_pkg::ADDR_CTRL) begin
        ctrl_reg <= reg_wdata_in & ~(8'h01 << bce_pkg::CTRL_START);
      end
      if (reg_addr_in == bce_pkg::ADDR_MASK) begin
        mask_reg <= reg_wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: idle, then a fixed count of run cycles
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= bce_pkg::BCE_IDLE;
      cnt_reg   <= '0;
    end else begin
      case (state_reg)
        bce_pkg::BCE_IDLE: begin
          cnt_reg <= '0;
          if (go) begin
            state_reg <= bce_pkg::BCE_RUN;
          end
        end
        bce_pkg::BCE_RUN: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (finish) begin
            state_reg <= bce_pkg::BCE_IDLE;
          end
        end
        default: begin
          state_reg <= bce_pkg::BCE_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // round datapath: keyed feistel network over two 64-bit halves
  function automatic logic [63:0] mix(input logic [63:0] x, input logic [63:0] k);
    logic [63:0] s;
    s   = x + k;
    mix = {s[50:0], s[63:51]} ^ {x[31:0], x[63:32]};
  endfunction : mix

  // decrypt walks the round keys backwards
  assign rnd  = ctrl_reg[bce_pkg::CTRL_DECRYPT]
                ? bce_pkg::CNT_W'(bce_pkg::ROUNDS) - cnt_reg : cnt_reg - 1'b1;
  assign rkey = (rnd[0] ? key_flat[63:0] : key_flat[127:64]) ^ 64'(rnd);

  always_comb begin
    if (ctrl_reg[bce_pkg::CTRL_DECRYPT]) begin
      work_next = {work_reg[63:0] ^ mix(work_reg[127:64], rkey), work_reg[127:64]};
    end else begin
      work_next = {work_reg[63:0], work_reg[127:64] ^ mix(work_reg[63:0], rkey)};
    end
  end

  // first run cycle captures the loaded block, then one round per cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      work_reg <= '0;
    end else if (busy && (cnt_reg == '0)) begin
      work_reg <= state_flat;
    end else if (busy && (cnt_reg <= bce_pkg::CNT_W'(bce_pkg::ROUNDS))) begin
      work_reg <= work_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion flags: set wins over clear
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_ev_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      if (finish) begin
        done_ev_reg <= 1'b1;
      end else if (rd_status) begin
        done_ev_reg <= 1'b0;
      end
      if (finish) begin
        done_reg <= 1'b1;
      end else if (go) begin
        done_reg <= 1'b0;
      end
    end
  end

  // transfer trigger pulses for the first cycle of a finished result
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dma_trig_out <= 1'b0;
    end else begin
      dma_trig_out <= finish;
    end
  end

  // interrupt level from unmasked sticky events
  assign irq_out = |({7'h00, done_ev_reg} & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read mux; state reads as zero while a run is in progress
  always_comb begin
    status_val = bce_pkg::ZERO_B;
    status_val[bce_pkg::ST_DONE_EV] = done_ev_reg;
    status_val[bce_pkg::ST_DONE]    = done_reg;
    status_val[bce_pkg::ST_BUSY]    = busy;
    rdata_next = bce_pkg::ZERO_B;
    if (reg_addr_in == bce_pkg::ADDR_CTRL) begin
      rdata_next = ctrl_reg;
    end else if (reg_addr_in == bce_pkg::ADDR_STATUS) begin
      rdata_next = status_val;
    end else if (reg_addr_in == bce_pkg::ADDR_MASK) begin
      rdata_next = mask_reg;
    end else if (is_state && !busy) begin
      rdata_next = state_flat[idx*8 +: 8];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= bce_pkg::ZERO_B;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_next;
    end else begin
      reg_rdata_out <= bce_pkg::ZERO_B;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks: helper counter of cycles since the last start
  logic [bce_pkg::CNT_W-1:0] sva_cnt_reg;
  logic [3:0]                sva_idx_reg;
  logic [7:0]                sva_exp_reg;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sva_cnt_reg <= '0;
      sva_idx_reg <= '0;
      sva_exp_reg <= '0;
    end else begin
      sva_cnt_reg <= go ? 9'h001 : ((&sva_cnt_reg) ? sva_cnt_reg : sva_cnt_reg + 1'b1);
      sva_idx_reg <= idx;
      sva_exp_reg <= reg_wdata_in ^ state_flat[idx*8 +: 8];
    end
  end

  latency_exact_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    dma_trig_out |-> sva_cnt_reg == bce_pkg::CNT_W'(bce_pkg::LATENCY))
    else $error("result not ready exactly at the latency");

  busy_state_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (reg_rd_in && is_state && busy) |=> reg_rdata_out == 8'h00)
    else $error("state readable while running");

  irq_enabled_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (dma_trig_out && mask_reg[bce_pkg::ST_DONE_EV]) |-> irq_out)
    else $error("enabled completion raised no interrupt");

  irq_disabled_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (mask_reg == 8'h00) |-> !irq_out)
    else $error("interrupt raised while disabled");

  dma_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $fell(busy_out) |-> dma_trig_out ##1 !dma_trig_out)
    else $error("trigger not a single pulse at completion");

  auto_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (reg_wr_in && is_state && idx == bce_pkg::LAST_BYTE && !busy && ctrl_reg[bce_pkg::CTRL_AUTO])
    |=> busy_out)
    else $error("auto-start did not begin a run");

  xor_load_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (wr_state && ctrl_reg[bce_pkg::CTRL_XOR] && !finish)
    |=> state_flat[sva_idx_reg*8 +: 8] == sva_exp_reg)
    else $error("xor load stored wrong byte");

  done_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    go |=> !done_reg throughout (busy_out [*2]))
    else $error("done flag not cleared by start");

  key_frozen_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (busy && reg_wr_in && is_key) |=> $stable(key_flat))
    else $error("key changed during a run");

  run_cov_c: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    go ##1 busy_out ##[1:400] dma_trig_out);
  auto_cov_c: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    auto_go ##[1:400] irq_out);
  dec_cov_c: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    dma_trig_out && ctrl_reg[bce_pkg::CTRL_DECRYPT]);

endmodule : bce_engine

// ===== test/bce_host_model.sv
// bus master model of the processor side of the engine
`timescale 1ns/1ps
module bce_host_model (
  input  wire logic       sys_clk_in,     // clock
  output logic      [7:0] reg_addr_out,   // register address
  output logic      [7:0] reg_wdata_out,  // write data
  output logic            reg_wr_out,     // write strobe
  output logic            reg_rd_out      // read strobe
);
  // idle bus at time zero
  initial begin
    reg_addr_out  = 8'hff;
    reg_wdata_out = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end

  // one strobed cycle; afterwards address and data turn to their inverse and strobes drop, so stale data never passes
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge sys_clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= w;
    reg_rd_out    <= ~w;
    @(posedge sys_clk_in);
    reg_wr_out    <= 1'b0;
    reg_rd_out    <= 1'b0;
    reg_addr_out  <= ~a;
    reg_wdata_out <= ~d;
  endtask : xfer

  // whole key and whole block go in before the control write that starts the run
  task automatic run(input logic [127:0] key, input logic [127:0] blk, input logic [7:0] ctrl);
    for (int i = 0; i < 16; i++) begin
      xfer({bce_pkg::PAGE_KEY, i[3:0]}, key[8*i +: 8], 1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      xfer({bce_pkg::PAGE_STATE, i[3:0]}, blk[8*i +: 8], 1'b1);
    end
    xfer(bce_pkg::ADDR_CTRL, ctrl, 1'b1);
  endtask : run
endmodule : bce_host_model

// ===== test/bce_engine_tb_top.sv
// self-checking testbench of the block cipher engine
`timescale 1ns/1ps
module bce_engine_tb_top;
  logic         sys_clk_in, rst_b_in, reg_wr, reg_rd, irq, dma_trig, busy, rd_seen;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata;
  logic [7:0]   exp_q [$];
  logic [7:0]   zero_addr [5] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h10};
  logic [31:0]  rnd;
  logic [127:0] key, pt, ct, xv;
  int           error_cnt, checks, cyc, n, nb, ni;

  bce_host_model i_host (.sys_clk_in(sys_clk_in), .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd));
  bce_engine i_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .irq_out(irq), .dma_trig_out(dma_trig), .busy_out(busy));

  ////////////////////////////////////////////////////////////////////////////
  // reference transform: sixteen feistel rounds
  function automatic logic [63:0] mix(input logic [63:0] x, input logic [63:0] k);
    logic [63:0] s;
    s = x + k;
    return {s[50:0], s[63:51]} ^ {x[31:0], x[63:32]};
  endfunction : mix

  function automatic logic [127:0] crypt(input logic [127:0] b, input logic [127:0] k,
                                         input logic dec);
    logic [63:0] l, r, t, kr;
    logic [3:0]  rr;
    l = b[127:64];
    r = b[63:0];
    for (int i = 0; i < 16; i++) begin
      rr = dec ? 4'(15 - i) : 4'(i);
      kr = (rr[0] ? k[63:0] : k[127:64]) ^ {60'h0, rr};
      t  = dec ? l : r;
      if (dec) begin
        l = r ^ mix(l, kr);
        r = t;
      end else begin
        r = l ^ mix(r, kr);
        l = t;
      end
    end
    return {l, r};
  endfunction : crypt

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic rand128(output logic [127:0] v);
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      v[32*i +: 32] = rnd;
    end
  endtask : rand128

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.xfer(a, 8'h00, 1'b0);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(a, d, 1'b1);
  endtask : wr

  // counts cycles up to the completion trigger, with busy and interrupt cycles
  task automatic wait_done();
    n  = 0;
    nb = 0;
    ni = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
      nb += (busy === 1'b1);
      ni += (irq === 1'b1);
    end while (dma_trig !== 1'b1 && n < 1000);
  endtask : wait_done

  task automatic results();
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // clock, hang guard and read data monitor
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      results();
    end
  end

  // read data stand only in the cycle after the strobe
  initial rd_seen = 1'b0;
  always @(posedge sys_clk_in) begin
    if (rd_seen && exp_q.size() > 0) chk({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    rd_seen <= reg_rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_b_in = 1'b0;
    rnd      = 32'h0000_ea48;
    repeat (16) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    chk({13'h0, irq, dma_trig, busy}, 16'h0000);
    foreach (zero_addr[i]) rd(zero_addr[i], 8'h00);
    wr(bce_pkg::ADDR_MASK, 8'h01);
    // two random encrypt runs with the interrupt enabled
    for (int t = 0; t < 2; t++) begin
      rand128(key);
      rand128(pt);
      i_host.run(key, pt, 8'h01);
      wait_done();
      chk(n[15:0], 16'd375);
      chk(nb[15:0], 16'd374);
      chk({15'h0, irq}, 16'h0001);
      @(negedge sys_clk_in);
      chk({15'h0, dma_trig}, 16'h0000);
      rd(bce_pkg::ADDR_STATUS, 8'h03);
      rd(bce_pkg::ADDR_STATUS, 8'h02);
      ct = crypt(pt, key, 1'b0);
      for (int i = 0; i < 16; i++) rd({bce_pkg::PAGE_STATE, i[3:0]}, ct[8*i +: 8]);
      @(negedge sys_clk_in);
      chk({15'h0, irq}, 16'h0000);
    end
    // masked decrypt, xor load, started by the last state byte
    wr(bce_pkg::ADDR_MASK, 8'h00);
    wr(bce_pkg::ADDR_CTRL, 8'h0e);
    rd(bce_pkg::ADDR_CTRL, 8'h0e);
    rand128(xv);
    for (int i = 0; i < 16; i++) wr({bce_pkg::PAGE_STATE, i[3:0]}, xv[8*i +: 8]);
    rd(bce_pkg::ADDR_STATUS, 8'h04);
    rd({bce_pkg::PAGE_STATE, 4'h0}, 8'h00);
    wr({bce_pkg::PAGE_KEY, 4'h0}, ~key[7:0]);
    wr(bce_pkg::ADDR_CTRL, 8'h0f);
    wait_done();
    chk(n[15:0], 16'd367);
    chk(ni[15:0], 16'd0);
    rd(bce_pkg::ADDR_STATUS, 8'h03);
    pt = crypt(ct ^ xv, key, 1'b1);
    for (int i = 0; i < 16; i++) rd({bce_pkg::PAGE_STATE, i[3:0]}, pt[8*i +: 8]);
    repeat (2) @(posedge sys_clk_in);
    results();
  end
endmodule : bce_engine_tb_top
